// ==== hw/dam_pkg.sv ====
// ----------------------------------------------------------------
// Address mapper constants and types
// ----------------------------------------------------------------
package dam_pkg;
  // Widths
  localparam int unsigned ADDR_W = 32; // Processor address
  localparam int unsigned MA_W = 13; // Memory address pins
  localparam int unsigned BA_W = 2; // Bank address pins
  localparam int unsigned CS_W = 2; // One select per side
  localparam int unsigned ORG_W = 4; // Organisation setting
  localparam int unsigned POS_W = 5; // Bit index width
  localparam int unsigned ROW_LO_W = 11; // Row bits 10..0
  localparam int unsigned COL_LO_W = 8; // Column bits 7..0

  // Fixed source positions in the processor address
  localparam int unsigned A_BS_HI = 23; // Bank select high
  localparam int unsigned A_BS_LO = 11; // Bank select low
  localparam int unsigned A_ROW_LO = 12; // Row bits 10..0 start
  localparam int unsigned A_R11 = 24; // Row bit 11
  localparam int unsigned A_R12 = 25; // Row bit 12
  localparam int unsigned A_COL_LO = 3; // Column bits 7..0 start

  // Memory address pin positions
  localparam int unsigned PIN_C8 = 8;
  localparam int unsigned PIN_C9 = 9;
  localparam int unsigned PIN_AP = 10; // Left free in column cycle
  localparam int unsigned PIN_C10 = 11; // Column bit 10 goes here
  localparam int unsigned PIN_R11 = 11;
  localparam int unsigned PIN_R12 = 12;

  // Select, reset and idle values
  localparam logic [CS_W-1:0] CS_IDLE = 2'h3;
  localparam logic [CS_W-1:0] CS_SIDE0 = 2'h2;
  localparam logic [CS_W-1:0] CS_SIDE1 = 2'h1;
  localparam logic [MA_W-1:0] MA_IDLE = 13'h0000;
  localparam logic [BA_W-1:0] BA_IDLE = 2'h0;

  // Four-bank organisations, capacity and width per device
  typedef enum logic [ORG_W-1:0] {
    ORG_64_X16, ORG_64_X8, ORG_64_X4,
    ORG_128_X16, ORG_128_X8, ORG_128_X4,
    ORG_256_X16, ORG_256_X8, ORG_256_X4,
    ORG_512_X16, ORG_512_X8
  } dam_org_t;
  localparam logic [ORG_W-1:0] ORG_NUM = 4'hB;

  // Column count above bit 7
  localparam logic [1:0] NCOL_0 = 2'h0;
  localparam logic [1:0] NCOL_1 = 2'h1;
  localparam logic [1:0] NCOL_2 = 2'h2;
  localparam logic [1:0] NCOL_3 = 2'h3;

  // One mapping: side, column 8/9/10 sources, column count, row 12
  typedef struct packed {
    logic [POS_W-1:0] side;
    logic [POS_W-1:0] c8;
    logic [POS_W-1:0] c9;
    logic [POS_W-1:0] c10;
    logic [1:0] ncol;
    logic r12;
  } dam_map_t;

  localparam dam_map_t MAP_TBL [0:10] = '{
    '{5'h19, 5'h00, 5'h00, 5'h00, 2'h0, 1'b0},
    '{5'h1A, 5'h19, 5'h00, 5'h00, 2'h1, 1'b0},
    '{5'h1B, 5'h19, 5'h1A, 5'h00, 2'h2, 1'b0},
    '{5'h1A, 5'h19, 5'h00, 5'h00, 2'h1, 1'b1},
    '{5'h1B, 5'h19, 5'h1A, 5'h00, 2'h2, 1'b1},
    '{5'h1C, 5'h19, 5'h1A, 5'h1B, 2'h3, 1'b1},
    '{5'h1B, 5'h1A, 5'h00, 5'h00, 2'h1, 1'b1},
    '{5'h1C, 5'h1A, 5'h1B, 5'h00, 2'h2, 1'b1},
    '{5'h1D, 5'h1A, 5'h1B, 5'h1C, 2'h3, 1'b1},
    '{5'h1C, 5'h1B, 5'h00, 5'h00, 2'h1, 1'b1},
    '{5'h1D, 5'h1B, 5'h1C, 5'h00, 2'h2, 1'b1}
  };
endpackage : dam_pkg

// ==== hw/dam_map_if.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Decoder hand-off between mapper and address splitter
// ----------------------------------------------------------------
interface dam_map_if;
  logic [dam_pkg::ADDR_W-1:0] addr; // Processor address
  logic [dam_pkg::ORG_W-1:0] org; // Organisation setting
  logic org_ok; // Setting is a supported one
  logic side; // Side select bit
  logic [dam_pkg::BA_W-1:0] bank; // Bank select pair
  logic [dam_pkg::MA_W-1:0] row_pins; // Row image on pins
  logic [dam_pkg::MA_W-1:0] col_pins; // Column image on pins

  modport dec (input addr, input org, output org_ok, output side,
    output bank, output row_pins, output col_pins);
  modport user (output addr, output org, input org_ok, input side,
    input bank, input row_pins, input col_pins);
endinterface : dam_map_if

// ==== hw/dam_addr_split.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Address splitter: processor address to side, bank, row, column
// ----------------------------------------------------------------
module dam_addr_split (
  // Decoder hand-off
  dam_map_if.dec m
);
  dam_pkg::dam_map_t ent; // Selected mapping entry

  // ----------------------------------------------------------------
  // Mapping lookup
  // ----------------------------------------------------------------
  // Pick the entry; unsupported settings fall back to entry zero
  always_comb begin
    m.org_ok = (m.org < dam_pkg::ORG_NUM);
    if (m.org_ok) begin
      ent = dam_pkg::MAP_TBL[m.org];
    end else begin
      ent = dam_pkg::MAP_TBL[0];
    end
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  // Build side, bank, row and column pin images; unused pins stay low
  always_comb begin
    m.side = m.addr[ent.side];
    m.bank = {m.addr[dam_pkg::A_BS_HI], m.addr[dam_pkg::A_BS_LO]};
    m.row_pins = dam_pkg::MA_IDLE;
    m.row_pins[dam_pkg::ROW_LO_W-1:0] =
      m.addr[dam_pkg::A_ROW_LO +: dam_pkg::ROW_LO_W];
    m.row_pins[dam_pkg::PIN_R11] = m.addr[dam_pkg::A_R11];
    // Row bit 12 only on 128 Mbit and larger
    m.row_pins[dam_pkg::PIN_R12] = ent.r12 & m.addr[dam_pkg::A_R12];
    m.col_pins = dam_pkg::MA_IDLE;
    m.col_pins[dam_pkg::COL_LO_W-1:0] =
      m.addr[dam_pkg::A_COL_LO +: dam_pkg::COL_LO_W];
    // Upper column bits by count; x4 parts of 128 Mbit and larger use all three
    if (ent.ncol >= dam_pkg::NCOL_1) begin
      m.col_pins[dam_pkg::PIN_C8] = m.addr[ent.c8];
    end
    if (ent.ncol >= dam_pkg::NCOL_2) begin
      m.col_pins[dam_pkg::PIN_C9] = m.addr[ent.c9];
    end
    if (ent.ncol == dam_pkg::NCOL_3) begin
      // Column bit 10 rides on pin 11, pin 10 stays low
      m.col_pins[dam_pkg::PIN_C10] = m.addr[ent.c10];
    end
  end
endmodule : dam_addr_split

// ==== hw/dam_addr_mapper.sv ====
`timescale 1ns/1ns
// Functional notes
// - fixed bank, row and low column sources
// - 4Mx16: side A25, no column 8+, no row12
// - 8Mx8: side A26, column 8 A25
// - 16Mx4: side A27, columns 9,8 A26,A25
// - 8Mx16: side A26, column 8 A25, row12 A25
// - 16Mx8: side A27, columns 9,8, row12 A25
// - 32Mx4: side A28, columns 10..8 A27..A25
// - 16Mx16: side A27, column 8 A26
// - 32Mx8: side A28, columns 9,8 A27,A26
// - 64Mx4: side A29, columns 10..8 A28..A26
// - 32Mx16: side A28, column 8 A27
// - 64Mx8: side A29, columns 9,8 A28,A27
// - column bit 10 on pin 11
// - side bit drives matching low select
// - only eleven four-bank organisations supported
// - thirteen address pins, separate two bank pins
// - row with row strobe, then column strobe
module dam_addr_mapper (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Configuration
  input wire logic [dam_pkg::ORG_W-1:0] cfg_org_i,
  output logic cfg_err_o,
  // Processor request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [dam_pkg::ADDR_W-1:0] req_addr_i,
  output logic req_ready_o,
  // SDRAM command and address pins
  output logic [dam_pkg::MA_W-1:0] mem_addr_o,
  output logic [dam_pkg::BA_W-1:0] mem_bank_o,
  output logic [dam_pkg::CS_W-1:0] mem_cs_n_o,
  output logic mem_ras_n_o,
  output logic mem_cas_n_o,
  output logic mem_we_n_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ROW, ST_COL} dam_state_t;

  dam_state_t state_r; // Command sequence state
  logic take; // Request accepted this cycle
  logic [dam_pkg::MA_W-1:0] col_r; // Column image held for CAS
  logic wr_r; // Write flag held for CAS
  logic [dam_pkg::ADDR_W-1:0] cap_addr_r; // Captured address
  logic [dam_pkg::ORG_W-1:0] cap_org_r; // Captured setting
  dam_map_if map (); // Splitter hand-off

  // ----------------------------------------------------------------
  // Address splitter
  // ----------------------------------------------------------------
  assign map.addr = req_addr_i;
  assign map.org = cfg_org_i;

  dam_addr_split u_split (
    .m(map)
  );

  // Accept only when idle and the setting is supported
  assign req_ready_o = (state_r == ST_IDLE) && map.org_ok;
  assign take = req_valid_i && req_ready_o;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Idle, row cycle, column cycle, back to idle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take) begin
            state_r <= ST_ROW;
          end
        end
        ST_ROW: begin
          state_r <= ST_COL;
        end
        ST_COL: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  // Hold column, write flag and source address for the whole command
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      col_r <= dam_pkg::MA_IDLE;
      wr_r <= 1'b0;
      cap_addr_r <= '0;
      cap_org_r <= '0;
    end else if (take) begin
      col_r <= map.col_pins;
      wr_r <= req_write_i;
      cap_addr_r <= req_addr_i;
      cap_org_r <= cfg_org_i;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Address pins: row on accept, column next, low when idle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_addr_o <= dam_pkg::MA_IDLE;
    end else if (take) begin
      mem_addr_o <= map.row_pins;
    end else if (state_r == ST_ROW) begin
      mem_addr_o <= col_r;
    end else begin
      mem_addr_o <= dam_pkg::MA_IDLE;
    end
  end

  // Bank and side select held for both command cycles
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_bank_o <= dam_pkg::BA_IDLE;
      mem_cs_n_o <= dam_pkg::CS_IDLE;
    end else if (take) begin
      mem_bank_o <= map.bank;
      mem_cs_n_o <= map.side ? dam_pkg::CS_SIDE1 : dam_pkg::CS_SIDE0;
    end else if (state_r == ST_COL) begin
      mem_bank_o <= dam_pkg::BA_IDLE;
      mem_cs_n_o <= dam_pkg::CS_IDLE;
    end
  end

  // Strobes: row strobe on row cycle, column strobe on column cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_ras_n_o <= 1'b1;
      mem_cas_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
    end else begin
      mem_ras_n_o <= !take;
      mem_cas_n_o <= (state_r != ST_ROW);
      mem_we_n_o <= !((state_r == ST_ROW) && wr_r);
    end
  end

  // Flag for an unsupported setting
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= !map.org_ok;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bank_src;
    @(posedge mclk_i) disable iff (!rstn_i)
    !mem_ras_n_o |-> mem_bank_o ==
      {cap_addr_r[dam_pkg::A_BS_HI], cap_addr_r[dam_pkg::A_BS_LO]};
  endproperty
  a_bank_src: assert property (p_bank_src) else $error("bank bits wrong");

  property p_row_src;
    @(posedge mclk_i) disable iff (!rstn_i)
    !mem_ras_n_o |-> mem_addr_o[dam_pkg::ROW_LO_W-1:0] ==
      cap_addr_r[dam_pkg::A_ROW_LO +: dam_pkg::ROW_LO_W]
      && mem_addr_o[dam_pkg::PIN_R11] == cap_addr_r[dam_pkg::A_R11];
  endproperty
  a_row_src: assert property (p_row_src) else $error("row bits wrong");

  property p_col_lo;
    @(posedge mclk_i) disable iff (!rstn_i)
    !mem_cas_n_o |-> mem_addr_o[dam_pkg::COL_LO_W-1:0] ==
      cap_addr_r[dam_pkg::A_COL_LO +: dam_pkg::COL_LO_W];
  endproperty
  a_col_lo: assert property (p_col_lo) else $error("low column wrong");

  property p_pin10_free;
    @(posedge mclk_i) disable iff (!rstn_i)
    !mem_cas_n_o |-> !mem_addr_o[dam_pkg::PIN_AP];
  endproperty
  a_pin10_free: assert property (p_pin10_free) else $error("pin 10 driven");

  property p_x16_64;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!mem_ras_n_o && cap_org_r == dam_pkg::ORG_64_X16) |->
      !mem_addr_o[dam_pkg::PIN_R12] ##1
      (mem_addr_o[dam_pkg::MA_W-1:dam_pkg::PIN_C8] == '0);
  endproperty
  a_x16_64: assert property (p_x16_64) else $error("4Mx16 extra bits");

  property p_side_sel;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!mem_ras_n_o && cap_org_r == dam_pkg::ORG_256_X4) |->
      mem_cs_n_o == (cap_addr_r[29] ? dam_pkg::CS_SIDE1 : dam_pkg::CS_SIDE0);
  endproperty
  a_side_sel: assert property (p_side_sel) else $error("side select wrong");

  property p_x4_128;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!mem_cas_n_o && cap_org_r == dam_pkg::ORG_128_X4) |->
      mem_addr_o[dam_pkg::PIN_C10] == cap_addr_r[27]
      && mem_addr_o[dam_pkg::PIN_C9:dam_pkg::PIN_C8] == cap_addr_r[26:25];
  endproperty
  a_x4_128: assert property (p_x4_128) else $error("32Mx4 column wrong");

  property p_ras_cas;
    @(posedge mclk_i) disable iff (!rstn_i)
    $fell(mem_ras_n_o) |=> !mem_cas_n_o && mem_ras_n_o
      && $stable(mem_cs_n_o) ##1 mem_cas_n_o;
  endproperty
  a_ras_cas: assert property (p_ras_cas) else $error("strobe order wrong");

  property p_take_ras;
    @(posedge mclk_i) disable iff (!rstn_i)
    (req_valid_i && req_ready_o) |=> (!mem_ras_n_o && !req_ready_o)
      ##1 (mem_ras_n_o && !req_ready_o);
  endproperty
  a_take_ras: assert property (p_take_ras) else $error("no row cycle");
endmodule : dam_addr_mapper

// ==== test/dam_sdram_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far-side memory model: latches row and column like a device
// ----------------------------------------------------------------
module dam_sdram_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // Command and address pins
  input wire logic [dam_pkg::MA_W-1:0] addr_i,
  input wire logic [dam_pkg::BA_W-1:0] bank_i,
  input wire logic [dam_pkg::CS_W-1:0] cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  // Captured access, shown one cycle after the column cycle
  output logic done_o,
  output logic [dam_pkg::MA_W-1:0] row_o,
  output logic [dam_pkg::MA_W-1:0] col_o,
  output logic [dam_pkg::BA_W-1:0] bank_o,
  output logic [dam_pkg::CS_W-1:0] cs_n_o,
  output logic wr_o,
  // Sticky flag for broken pin sequencing
  output logic err_o
);
  logic act_r; // Row strobe seen in the previous cycle

  // Latch on the rising edge after each strobe, as a device does
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      act_r <= 1'b0;
      err_o <= 1'b0;
      row_o <= 13'h0000;
      col_o <= 13'h0000;
      bank_o <= 2'h0;
      cs_n_o <= 2'h3;
      wr_o <= 1'b0;
    end else begin
      done_o <= !cas_n_i;
      act_r <= !ras_n_i;
      // Row cycle: capture row, bank and side
      if (!ras_n_i) begin
        row_o <= addr_i;
        bank_o <= bank_i;
        cs_n_o <= cs_n_i;
        if (cs_n_i == 2'h3 || cs_n_i == 2'h0 || !cas_n_i) begin
          err_o <= 1'b1;
        end
      end
      // Column cycle: must follow the row cycle with bank and side held
      if (!cas_n_i) begin
        col_o <= addr_i;
        wr_o <= !we_n_i;
        if (!act_r || bank_i != bank_o || cs_n_i != cs_n_o) begin
          err_o <= 1'b1;
        end
      end
      // Idle: pins parked low, no side selected, no write
      if (ras_n_i && cas_n_i && (addr_i != 13'h0000 || cs_n_i != 2'h3 || !we_n_i)) begin
        err_o <= 1'b1;
      end
    end
  end
endmodule : dam_sdram_model

// ==== test/dam_addr_mapper_tb.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, got, exp); end end
// ----------------------------------------------------------------
// Self-checking bench for the address mapper
// ----------------------------------------------------------------
module dam_addr_mapper_tb;
  // Expected access as the memory should see it
  typedef struct packed {
    logic [12:0] row;
    logic [12:0] col;
    logic [1:0] bank;
    logic [1:0] cs_n;
    logic wr;
  } dam_exp_t;

  // Source bit per organisation, 0 means not driven
  localparam int SIDE_SRC [0:10] = '{25, 26, 27, 26, 27, 28, 27, 28, 29, 28, 29};
  localparam int C8_SRC [0:10] = '{0, 25, 25, 25, 25, 25, 26, 26, 26, 27, 27};
  localparam int C9_SRC [0:10] = '{0, 0, 26, 0, 26, 26, 0, 27, 27, 0, 28};
  localparam int C10_SRC [0:10] = '{0, 0, 0, 0, 0, 27, 0, 0, 28, 0, 0};

  logic mclk = 1'b0; // Memory clock
  logic rst_n = 1'b0; // Active-low reset
  logic [3:0] org = 4'h0; // Organisation setting
  logic valid = 1'b0; // Request valid
  logic wr = 1'b0; // Request is a write
  logic [31:0] addr = 32'h00000000; // Request address
  logic cfg_err, ready, ras_n, cas_n, we_n;
  logic [12:0] ma;
  logic [1:0] ba, cs_n;
  logic m_done, m_wr, m_err;
  logic [12:0] m_row, m_col;
  logic [1:0] m_bank, m_cs_n;
  dam_exp_t exp_q [$]; // Pending expectations
  dam_exp_t e; // Expectation under comparison
  int err_total = 0;
  int check_count = 0;
  integer seed = 11;

  // Clock at 125 MHz
  always #4 mclk = ~mclk;

  dam_addr_mapper DUT (.mclk_i(mclk), .rstn_i(rst_n), .cfg_org_i(org), .cfg_err_o(cfg_err),
    .req_valid_i(valid), .req_write_i(wr), .req_addr_i(addr), .req_ready_o(ready),
    .mem_addr_o(ma), .mem_bank_o(ba), .mem_cs_n_o(cs_n), .mem_ras_n_o(ras_n),
    .mem_cas_n_o(cas_n), .mem_we_n_o(we_n));

  dam_sdram_model MEM (.mclk_i(mclk), .rstn_i(rst_n), .addr_i(ma), .bank_i(ba),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .done_o(m_done),
    .row_o(m_row), .col_o(m_col), .bank_o(m_bank), .cs_n_o(m_cs_n), .wr_o(m_wr),
    .err_o(m_err));

  // Expected pins worked out from the mapping table
  function automatic dam_exp_t exp_of(input logic [3:0] o, input logic [31:0] a,
                                      input logic w);
    dam_exp_t x;
    x.row = {(o > 4'h2) ? a[25] : 1'b0, a[24], a[22:12]};
    x.col = 13'h0000;
    x.col[7:0] = a[10:3];
    if (C8_SRC[o] != 0) x.col[8] = a[C8_SRC[o]];
    if (C9_SRC[o] != 0) x.col[9] = a[C9_SRC[o]];
    if (C10_SRC[o] != 0) x.col[11] = a[C10_SRC[o]];
    x.bank = {a[23], a[11]};
    x.cs_n = a[SIDE_SRC[o]] ? 2'h1 : 2'h2;
    x.wr = w;
    return x;
  endfunction : exp_of

  // Print verdict and stop
  task automatic end_sim();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // One request, held until the mapper takes it
  task automatic send(input logic [31:0] a, input logic w);
    int n;
    n = 0;
    addr = a;
    wr = w;
    valid = 1'b1;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // A request that is never taken counts against the run
    if (n >= 50) begin
      err_total++;
      $display("[ERR] %0t request never taken", $time);
    end
    exp_q.push_back(exp_of(org, a, w));
    @(posedge mclk);
    #1;
  endtask : send

  // Compare each access seen by the memory with the oldest note
  always @(posedge mclk) begin
    if (m_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] %0t access without request", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(m_row, e.row)
        `CHK(m_col, e.col)
        `CHK(m_bank, e.bank)
        `CHK(m_cs_n, e.cs_n)
        `CHK(m_wr, e.wr)
      end
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    `CHK(cs_n, 2'h3)
    `CHK(ma, 13'h0000)
    // Every organisation, back-to-back random and all-ones addresses
    for (int o = 0; o < 11; o++) begin
      org = o[3:0];
      for (int i = 0; i < 12; i++) begin
        send((i == 0) ? 32'hFFFFFFFF : $random(seed), $random(seed) % 2 != 0);
      end
    end
    valid = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    // Unsupported setting: flag raised, request refused
    org = 4'hC;
    valid = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(cfg_err, 1'b1)
    `CHK(ready, 1'b0)
    valid = 1'b0;
    @(posedge mclk);
    #1;
    org = 4'hA;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(cfg_err, 1'b0)
    `CHK(exp_q.size(), 0)
    `CHK(m_err, 1'b0)
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial begin
    #20000;
    err_total++;
    end_sim();
  end
endmodule : dam_addr_mapper_tb
